// ### fsesq_host.sv
// Purpose: host controller issuing flash command sequences from AXI4-Lite orders
// Assumes: flash data inputs synchronous to aclk
// Notes: one write cycle is setup, strobe low, strobe high, release (four clocks)
//
// Behaviour
// - High voltage on accel pin only during accelerated programming.
// - Chip erase is six writes: two unlocks, setup, two unlocks, chip erase.
// - Sector erase is six writes, last one at the sector address.
// - More sectors queued within 50 us of the last write strobe rise.
// - Suspend is one write of B0 at any address.
// - Resume is one write of 30 at any address.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.

`timescale 1ns/1ps

module fsesq_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Flash pins
  input wire logic [15:0] dq_in,
  output fsesq_pkg::fsesq_pins_type pins
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_SETUP = 6'b00_0010,
    ST_STROBE = 6'b00_0100,
    ST_HOLD = 6'b00_1000,
    ST_READ = 6'b01_0000,
    ST_RESET = 6'b10_0000
  } fsesq_state_type;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] fsesq_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic fsesq_pkg::fsesq_cycle_type fsesq_step(fsesq_pkg::fsesq_cmd_type c, logic [2:0] i,
      logic [21:0] a, logic [15:0] d);
    fsesq_pkg::fsesq_cycle_type r;
    logic [2:0] n;
    r = '{last: 1'b1, addr: a, data: d};
    case (c)
      fsesq_pkg::CMD_PROG: n = 3'd3;
      fsesq_pkg::CMD_CHIP, fsesq_pkg::CMD_SECT: n = 3'd5;
      fsesq_pkg::CMD_ACCEL: n = 3'd1;
      default: n = 3'd0;
    endcase
    r.last = (i == n);
    case (c)
      fsesq_pkg::CMD_PROG, fsesq_pkg::CMD_CHIP, fsesq_pkg::CMD_SECT: begin
        if (i == 3'd0 || (i == 3'd3 && c != fsesq_pkg::CMD_PROG)) begin
          r.addr = fsesq_pkg::ADDR_U1;
          r.data = fsesq_pkg::CODE_U1;
        end else if (i == 3'd1 || i == 3'd4) begin
          r.addr = fsesq_pkg::ADDR_U2;
          r.data = fsesq_pkg::CODE_U2;
        end else if (i == 3'd2) begin
          r.addr = fsesq_pkg::ADDR_U1;
          r.data = (c == fsesq_pkg::CMD_PROG) ? fsesq_pkg::CODE_PROG : fsesq_pkg::CODE_SETUP;
        end else if (i == 3'd5 && c == fsesq_pkg::CMD_CHIP) begin
          r.addr = fsesq_pkg::ADDR_U1;
          r.data = fsesq_pkg::CODE_CHIP;
        end else if (i == 3'd5) begin
          r.data = fsesq_pkg::CODE_SECT;
        end
      end
      fsesq_pkg::CMD_SADD: r.data = fsesq_pkg::CODE_SECT;
      fsesq_pkg::CMD_SUSP: begin
        r.addr = fsesq_pkg::ADDR_ANY;
        r.data = fsesq_pkg::CODE_SUSP;
      end
      fsesq_pkg::CMD_RESUME: begin
        r.addr = fsesq_pkg::ADDR_ANY;
        r.data = fsesq_pkg::CODE_RESUME;
      end
      fsesq_pkg::CMD_RESET: begin
        r.addr = fsesq_pkg::ADDR_ANY;
        r.data = fsesq_pkg::CODE_RESET;
      end
      fsesq_pkg::CMD_ACCEL: begin
        if (i == 3'd0) begin
          r.addr = fsesq_pkg::ADDR_ANY;
          r.data = fsesq_pkg::CODE_PROG;
        end
      end
      default: r.last = 1'b1;
    endcase
    return r;
  endfunction

  // ****************************************
  // State
  // ****************************************
  fsesq_state_type state;
  fsesq_pkg::fsesq_cmd_type cur_cmd;
  fsesq_pkg::fsesq_cmd_type cmd_req;
  fsesq_pkg::fsesq_cycle_type cyc;
  logic [2:0] step;
  logic [3:0] cnt;
  logic [21:0] reg_addr;
  logic [15:0] reg_data;
  logic [21:0] op_addr;
  logic [15:0] op_data;
  logic [15:0] read_data;
  logic [9:0] win_cnt;
  logic win_run;
  logic refused;
  logic start_req;
  logic aw_got;
  logic w_got;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_commit;
  logic busy;
  logic sadd_late;
  logic set_refuse;
  logic [2:0] we_cnt;

  assign cyc = fsesq_step(cur_cmd, step, op_addr, op_data);
  assign busy = (state != ST_IDLE) || start_req;
  assign sadd_late = !win_run || (win_cnt >= fsesq_pkg::WIN_LIMIT);
  assign wr_commit = aw_got && w_got && !bvalid;
  assign set_refuse = wr_commit && wr_addr == fsesq_pkg::OFF_CTRL && wr_strb[0] &&
    (busy || (fsesq_pkg::fsesq_cmd_type'(wr_data[3:0]) == fsesq_pkg::CMD_SADD && sadd_late));

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= fsesq_pkg::RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        awready <= 1'b0;
        wr_addr <= awaddr;
      end else if (bvalid && bready) begin
        aw_got <= 1'b0;
        awready <= 1'b1;
      end else begin
        awready <= !aw_got;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end else if (bvalid && bready) begin
        w_got <= 1'b0;
        wready <= 1'b1;
      end else begin
        wready <= !w_got;
      end
      if (wr_commit) begin
        bvalid <= 1'b1;
        bresp <= (wr_addr == fsesq_pkg::OFF_CTRL || wr_addr == fsesq_pkg::OFF_ADDR ||
          wr_addr == fsesq_pkg::OFF_DATA || wr_addr == fsesq_pkg::OFF_STATUS) ?
          fsesq_pkg::RESP_OKAY : fsesq_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_addr <= 22'h00_0000;
      reg_data <= 16'h0000;
      refused <= 1'b0;
      start_req <= 1'b0;
      cmd_req <= fsesq_pkg::CMD_READ;
    end else begin
      start_req <= 1'b0;
      if (wr_commit && wr_addr == fsesq_pkg::OFF_ADDR) begin
        reg_addr <= 22'(fsesq_merge({10'h000, reg_addr}, wr_data, wr_strb));
      end
      if (wr_commit && wr_addr == fsesq_pkg::OFF_DATA) begin
        reg_data <= 16'(fsesq_merge({16'h0000, reg_data}, wr_data, wr_strb));
      end
      if (wr_commit && wr_addr == fsesq_pkg::OFF_CTRL && wr_strb[0] && !set_refuse) begin
        start_req <= 1'b1;
        cmd_req <= fsesq_pkg::fsesq_cmd_type'(wr_data[3:0]);
      end
      // Set wins over clear
      if (set_refuse) begin
        refused <= 1'b1;
      end else if (wr_commit && wr_addr == fsesq_pkg::OFF_STATUS && wr_strb[0] &&
          wr_data[fsesq_pkg::ST_REFUSE_BIT]) begin
        refused <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= fsesq_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= fsesq_pkg::RESP_OKAY;
      case (araddr)
        fsesq_pkg::OFF_CTRL: rdata <= {28'h000_0000, cur_cmd};
        fsesq_pkg::OFF_ADDR: rdata <= {10'h000, reg_addr};
        fsesq_pkg::OFF_DATA: rdata <= {16'h0000, reg_data};
        fsesq_pkg::OFF_STATUS: rdata <= {29'h0000_0000, refused, win_run, busy};
        fsesq_pkg::OFF_RDATA: rdata <= {16'h0000, read_data};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= fsesq_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // ****************************************
  // Flash cycle sequencer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cur_cmd <= fsesq_pkg::CMD_READ;
      step <= 3'd0;
      cnt <= 4'h0;
      op_addr <= 22'h00_0000;
      op_data <= 16'h0000;
      read_data <= 16'h0000;
      pins <= fsesq_pkg::PINS_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            cur_cmd <= cmd_req;
            op_addr <= reg_addr;
            op_data <= reg_data;
            step <= 3'd0;
            cnt <= 4'h0;
            if (cmd_req == fsesq_pkg::CMD_HWRST) begin
              pins.reset_n <= 1'b0;
              state <= ST_RESET;
            end else if (cmd_req == fsesq_pkg::CMD_READ) begin
              pins.addr <= reg_addr;
              pins.ce_n <= 1'b0;
              pins.oe_n <= 1'b0;
              state <= ST_READ;
            end else begin
              pins.accel <= (cmd_req == fsesq_pkg::CMD_ACCEL);
              state <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          pins.addr <= cyc.addr;
          pins.dq_out <= cyc.data;
          pins.dq_oe <= 1'b1;
          pins.ce_n <= 1'b0;
          state <= ST_STROBE;
        end
        ST_STROBE: begin
          pins.we_n <= 1'b0;
          state <= ST_HOLD;
        end
        ST_HOLD: begin
          if (!pins.we_n) begin
            pins.we_n <= 1'b1;
          end else begin
            pins.ce_n <= 1'b1;
            pins.dq_oe <= 1'b0;
            if (cyc.last) begin
              pins.accel <= 1'b0;
              state <= ST_IDLE;
            end else begin
              step <= step + 3'd1;
              state <= ST_SETUP;
            end
          end
        end
        ST_READ: begin
          cnt <= cnt + 4'h1;
          if (cnt >= fsesq_pkg::ACC_CNT) begin
            read_data <= dq_in;
            pins.ce_n <= 1'b1;
            pins.oe_n <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_RESET: begin
          cnt <= cnt + 4'h1;
          if (cnt + 4'h1 >= fsesq_pkg::HWRST_CNT) begin
            pins.reset_n <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Sector erase window timer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_run <= 1'b0;
      win_cnt <= 10'h000;
    end else if (state == ST_HOLD && !pins.we_n && cyc.last &&
        (cur_cmd == fsesq_pkg::CMD_SECT || cur_cmd == fsesq_pkg::CMD_SADD)) begin
      win_run <= 1'b1;
      win_cnt <= 10'h000;
    end else if (state == ST_IDLE && start_req && cmd_req != fsesq_pkg::CMD_SADD) begin
      win_run <= 1'b0;
    end else if (win_run) begin
      win_cnt <= win_cnt + 10'h001;
      if (win_cnt + 10'h001 >= fsesq_pkg::WIN_END) begin
        win_run <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn || (state == ST_IDLE && start_req)) begin
      we_cnt <= 3'd0;
    end else if (state == ST_STROBE) begin
      we_cnt <= we_cnt + 3'd1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_one_write;
    (state == ST_SETUP) ##1 (state == ST_STROBE) ##1 (state == ST_HOLD) [*2] ##1 (state == ST_IDLE);
  endsequence

  a_accel_only_prog: assert property (pins.accel |-> cur_cmd == fsesq_pkg::CMD_ACCEL && state != ST_IDLE)
    else $error("accel pin raised outside accelerated program");
  a_chip_six_writes: assert property ($rose(pins.we_n) && cur_cmd == fsesq_pkg::CMD_CHIP && cyc.last
      |-> we_cnt == 3'd6 && pins.dq_out == fsesq_pkg::CODE_CHIP)
    else $error("chip erase not six writes");
  a_sector_last_write: assert property ($rose(pins.we_n) && cur_cmd == fsesq_pkg::CMD_SECT && cyc.last
      |-> we_cnt == 3'd6 && pins.dq_out == fsesq_pkg::CODE_SECT &&
        pins.addr[fsesq_pkg::SECT_HI:fsesq_pkg::SECT_LO] == op_addr[fsesq_pkg::SECT_HI:fsesq_pkg::SECT_LO])
    else $error("sector erase last write wrong");
  a_window_gap_held: assert property ($rose(pins.we_n) && cur_cmd == fsesq_pkg::CMD_SADD
      |-> $past(win_run) && $past(win_cnt) < fsesq_pkg::WIN_END)
    else $error("sector added after window closed");
  a_suspend_single: assert property (state == ST_IDLE && start_req && cmd_req == fsesq_pkg::CMD_SUSP
      |=> s_one_write)
    else $error("suspend is not one write");
  a_suspend_code: assert property ($rose(pins.we_n) && cur_cmd == fsesq_pkg::CMD_SUSP
      |-> pins.dq_out == fsesq_pkg::CODE_SUSP)
    else $error("suspend code wrong");
  a_resume_single: assert property (state == ST_IDLE && start_req && cmd_req == fsesq_pkg::CMD_RESUME
      |=> s_one_write ##0 $past(pins.dq_out, 2) == fsesq_pkg::CODE_RESUME)
    else $error("resume is not one write of its code");

endmodule

// ### fsesq_pkg.sv
// Purpose: constants and types of the flash erase/suspend sequencer host
// Assumes: 10 MHz aclk, 16-bit flash data bus
// Notes: register map of the host controller and flash command codes

package fsesq_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 10;
  localparam int WIN_US = 50;
  localparam int WIN_CYC = WIN_US * CLK_MHZ;
  localparam int WR_CYC = 5;
  localparam logic [9:0] WIN_LIMIT = 10'(WIN_CYC - WR_CYC);
  localparam logic [9:0] WIN_END = 10'(WIN_CYC);
  localparam int ACC_NS = 90;
  localparam logic [3:0] ACC_CNT = 4'((ACC_NS * CLK_MHZ + 999) / 1000);
  localparam int HWRST_NS = 500;
  localparam logic [3:0] HWRST_CNT = 4'((HWRST_NS * CLK_MHZ + 999) / 1000);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WIN_BIT = 1;
  localparam int ST_REFUSE_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Flash command codes
  // ****************************************
  localparam logic [21:0] ADDR_U1 = 22'h00_0555;
  localparam logic [21:0] ADDR_U2 = 22'h00_02aa;
  localparam logic [21:0] ADDR_ANY = 22'h00_0000;
  localparam logic [15:0] CODE_U1 = 16'h00aa;
  localparam logic [15:0] CODE_U2 = 16'h0055;
  localparam logic [15:0] CODE_PROG = 16'h00a0;
  localparam logic [15:0] CODE_SETUP = 16'h0080;
  localparam logic [15:0] CODE_CHIP = 16'h0010;
  localparam logic [15:0] CODE_SECT = 16'h0030;
  localparam logic [15:0] CODE_SUSP = 16'h00b0;
  localparam logic [15:0] CODE_RESUME = 16'h0030;
  localparam logic [15:0] CODE_RESET = 16'h00f0;
  localparam int SECT_HI = 20;
  localparam int SECT_LO = 15;

  typedef enum logic [3:0] {
    CMD_READ = 4'h0,
    CMD_PROG = 4'h1,
    CMD_CHIP = 4'h2,
    CMD_SECT = 4'h3,
    CMD_SADD = 4'h4,
    CMD_SUSP = 4'h5,
    CMD_RESUME = 4'h6,
    CMD_ACCEL = 4'h7,
    CMD_RESET = 4'h8,
    CMD_HWRST = 4'h9
  } fsesq_cmd_type;

  typedef struct packed {
    logic last;
    logic [21:0] addr;
    logic [15:0] data;
  } fsesq_cycle_type;

  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic accel;
  } fsesq_pins_type;

  localparam fsesq_pins_type PINS_IDLE = '{addr: 22'h00_0000, dq_out: 16'h0000, dq_oe: 1'b0,
    ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, accel: 1'b0};

endpackage

// ### fsesq_flash_model.sv
// Purpose: behavioural flash device facing the sequencer host
// Assumes: timers tick once a microsecond; an erase lasts ERASE_US
// Notes: sparse array, absent words read as erased
`timescale 1ns/1ps
module fsesq_flash_model #(
  parameter int ERASE_US = 100
) (
  // Flash pins
  input wire fsesq_pkg::fsesq_pins_type pins,
  output logic [15:0] dq
);
  localparam logic [37:0] U1 = {fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_U1};
  localparam logic [37:0] U2 = {fsesq_pkg::ADDR_U2, fsesq_pkg::CODE_U2};
  localparam logic [37:0] SU = {fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_SETUP};
  localparam logic [37:0] PS = {fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_PROG};
  logic [15:0] mem [logic [21:0]];
  logic [21:0] kill [$];
  logic [5:0][37:0] h = '0;
  logic [63:0] sel = '0;
  // Mode 0 read, 1 window, 2 erasing, 3 suspended
  logic [1:0] mode = 2'd0;
  logic chip = 1'b0;
  logic tog = 1'b0;
  logic [15:0] rv;
  logic [15:0] d;
  int t = 0;
  wire [5:0] rs = pins.addr[20:15];

  // ****************************************
  // Command decode
  // ****************************************
  always @(posedge pins.we_n or negedge pins.reset_n) begin
    if (!pins.reset_n) begin
      mode = 2'd0;
      chip = 1'b0;
    end else if (!pins.ce_n && !chip) begin
      h = {h[4:0], pins.addr, pins.dq_out};
      d = pins.dq_out;
      // Programs finish at their strobe, so a program suspend never waits
      if (d == fsesq_pkg::CODE_SUSP && (mode == 2'd1 || mode == 2'd2)) begin
        mode = 2'd3;
        t = 0;
      end else if (mode == 2'd1 && d == fsesq_pkg::CODE_SECT) begin
        sel[rs] = 1'b1;
        t = 0;
      end else if (mode == 2'd1) begin
        mode = 2'd0;
        sel = '0;
      // Any other code, autoselect exit included, leaves the suspend in place
      end else if (mode == 2'd3 && d == fsesq_pkg::CODE_RESUME) begin
        mode = 2'd2;
      end else if (mode == 2'd0 && h[5:1] == {U1, U2, SU, U1, U2}) begin
        chip = d == fsesq_pkg::CODE_CHIP;
        mode = chip ? 2'd2 : 2'd1;
        sel = chip ? '0 : 64'(1) << rs;
        t = 0;
      end else if (mode != 2'd2 && (h[3:1] == {U1, U2, PS} || pins.accel && h[1][15:0] == fsesq_pkg::CODE_PROG)) begin
        if (!(mode == 2'd3 && sel[rs])) mem[pins.addr] = rv & d;
      end
    end
  end

  // ****************************************
  // Timers and read path
  // ****************************************
  always #1000 begin
    if (mode != 2'd3) t = t + 1;
    if (mode == 2'd1 && t >= fsesq_pkg::WIN_US) begin
      mode = 2'd2;
      t = 0;
    end else if (mode == 2'd2 && t >= ERASE_US) begin
      foreach (mem[a]) begin
        if (chip || sel[a[20:15]]) kill.push_back(a);
      end
      foreach (kill[i]) mem.delete(kill[i]);
      kill = {};
      mode = 2'd0;
      chip = 1'b0;
      sel = '0;
    end
  end
  always @(posedge pins.oe_n) tog = ~tog;
  always @* begin
    if (mode[1] != mode[0] && (chip || sel[rs])) rv = {8'h00, 1'b0, tog, 2'b00, mode[1], tog, 2'b00};
    else if (mode == 2'd3 && sel[rs]) rv = {8'h00, 1'b1, 4'h0, tog, 2'b00};
    else rv = mem.exists(pins.addr) ? mem[pins.addr] : 16'hffff;
  end
  // Released bus shows the inverse, never a stale value
  assign dq = !pins.ce_n && !pins.oe_n ? rv : ~rv;
endmodule

// ### fsesq_host_tb.sv
// Purpose: self-checking bench of the flash sequencer host
// Assumes: model erase lasts 100 us
// Notes: write cycles on the pins are checked against notes queued by the driver
`timescale 1ns/1ps
module fsesq_host_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] dq_in, mdq, pd;
  logic [21:0] pa, sa;
  logic [40:0] nx;
  fsesq_pkg::fsesq_pins_type pins;
  logic [40:0] cq [$];
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int lowc = 0;

  fsesq_host dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .dq_in(dq_in), .pins(pins));
  fsesq_flash_model #(.ERASE_US(100)) flash (.pins(pins), .dq(mdq));
  assign dq_in = pins.dq_oe ? pins.dq_out : mdq;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [40:0] seen, input logic [40:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic ex(input logic care, input logic acc, input logic [21:0] a, input logic [15:0] d);
    cq.push_back({care, acc, 1'b1, a, d});
  endtask
  task automatic st(input logic [31:0] d);
    rd(fsesq_pkg::OFF_STATUS, d, fsesq_pkg::RESP_OKAY);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [7:0] a, input logic [31:0] v);
    if (a != fsesq_pkg::OFF_CTRL) wr(a, v, fsesq_pkg::RESP_OKAY);
    wr(fsesq_pkg::OFF_CTRL, 32'(c), fsesq_pkg::RESP_OKAY);
    while (cq.size() != 0) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask
  task automatic erase6(input logic [21:0] a, input logic [15:0] c);
    ex(1, 0, fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_U1);
    ex(1, 0, fsesq_pkg::ADDR_U2, fsesq_pkg::CODE_U2);
    ex(1, 0, fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_SETUP);
    ex(1, 0, fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_U1);
    ex(1, 0, fsesq_pkg::ADDR_U2, fsesq_pkg::CODE_U2);
    ex(1, 0, a, c);
  endtask

  // ****************************************
  // Monitors
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      test_done;
    end
  end
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) chk(41'(bresp), 41'(bq.pop_front()));
    if (rvalid === 1'b1 && rready) chk(41'({rresp, rdata}), 41'(rq.pop_front()));
    if (aresetn && !pins.reset_n) lowc++;
    else if (lowc != 0) begin
      chk(41'(lowc), 41'(fsesq_pkg::HWRST_CNT));
      lowc = 0;
    end
  end
  always @(posedge pins.we_n) begin
    if (aresetn && !pins.ce_n) begin
      nx = cq.size() != 0 ? cq.pop_front() : '0;
      chk({nx[40], pins.accel, pins.dq_oe && pins.oe_n, nx[40] ? pins.addr : nx[37:16], pins.dq_out}, nx);
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    void'($urandom(5051));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    st(32'h0000_0000);
    rd(8'h14, 32'h0000_0000, fsesq_pkg::RESP_SLVERR);
    wr(8'h20, 32'hffff_ffff, fsesq_pkg::RESP_SLVERR);
    erase6(fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_CHIP);
    wr(fsesq_pkg::OFF_CTRL, 32'h0000_0002, fsesq_pkg::RESP_OKAY);
    cmd(4'h5, fsesq_pkg::OFF_CTRL, 32'h0000_0000);
    st(32'h0000_0004);
    wr(fsesq_pkg::OFF_STATUS, 32'h0000_0004, fsesq_pkg::RESP_OKAY);
    st(32'h0000_0000);
    // Model chip erase runs 100 us
    repeat (1100) @(posedge aclk);
    pa = {7'h00, 15'($urandom)};
    pd = 16'($urandom);
    sa = {1'b0, 6'($urandom_range(62, 1)), 15'h0000};
    wr(fsesq_pkg::OFF_DATA, 32'(pd), fsesq_pkg::RESP_OKAY);
    ex(1, 0, fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_U1);
    ex(1, 0, fsesq_pkg::ADDR_U2, fsesq_pkg::CODE_U2);
    ex(1, 0, fsesq_pkg::ADDR_U1, fsesq_pkg::CODE_PROG);
    ex(1, 0, pa, pd);
    cmd(4'h1, fsesq_pkg::OFF_ADDR, 32'(pa));
    erase6(sa, fsesq_pkg::CODE_SECT);
    cmd(4'h3, fsesq_pkg::OFF_ADDR, 32'(sa));
    st(32'h0000_0002);
    sa[20:15] = sa[20:15] + 6'h01;
    ex(1, 0, sa, fsesq_pkg::CODE_SECT);
    cmd(4'h4, fsesq_pkg::OFF_ADDR, 32'(sa));
    st(32'h0000_0002);
    ex(1, 0, fsesq_pkg::ADDR_ANY, fsesq_pkg::CODE_SUSP);
    cmd(4'h5, fsesq_pkg::OFF_CTRL, 32'h0000_0000);
    st(32'h0000_0000);
    cmd(4'h0, fsesq_pkg::OFF_ADDR, 32'(pa));
    repeat (8) @(posedge aclk);
    rd(fsesq_pkg::OFF_RDATA, 32'(pd), fsesq_pkg::RESP_OKAY);
    ex(1, 0, fsesq_pkg::ADDR_ANY, fsesq_pkg::CODE_RESUME);
    cmd(4'h6, fsesq_pkg::OFF_CTRL, 32'h0000_0000);
    cmd(4'h4, fsesq_pkg::OFF_CTRL, 32'h0000_0000);
    st(32'h0000_0004);
    wr(fsesq_pkg::OFF_STATUS, 32'h0000_0004, fsesq_pkg::RESP_OKAY);
    pa = pa ^ 22'h00_0001;
    pd = 16'($urandom);
    wr(fsesq_pkg::OFF_DATA, 32'(pd), fsesq_pkg::RESP_OKAY);
    ex(0, 1, fsesq_pkg::ADDR_ANY, fsesq_pkg::CODE_PROG);
    ex(1, 1, pa, pd);
    cmd(4'h7, fsesq_pkg::OFF_ADDR, 32'(pa));
    rd(fsesq_pkg::OFF_CTRL, 32'h0000_0007, fsesq_pkg::RESP_OKAY);
    cmd(4'h9, fsesq_pkg::OFF_CTRL, 32'h0000_0000);
    repeat (8) @(posedge aclk);
    ex(1, 0, fsesq_pkg::ADDR_ANY, fsesq_pkg::CODE_RESET);
    cmd(4'h8, fsesq_pkg::OFF_CTRL, 32'h0000_0000);
    rd(fsesq_pkg::OFF_CTRL, 32'h0000_0008, fsesq_pkg::RESP_OKAY);
    st(32'h0000_0000);
    chk(41'(cq.size()), 41'd0);
    test_done;
  end
endmodule
